// ===== src/mdc_pkg.sv
// Purpose: shared constants and types of the multichannel dma controller
// Assumes: 32-bit ahb-lite register bus, 16-bit transaction bus
// Notes:   every register offset is a byte address on the register bus
package mdc_pkg;

   // ---------------------------------------------------------------
   // geometry
   // ---------------------------------------------------------------
   localparam int NCH = 8;
   localparam int CNT_W = 10;
   localparam int SRC_W = 7;
   localparam int NSRC = 128;

   // ---------------------------------------------------------------
   // register map (channel x at x * CH_STRIDE)
   // ---------------------------------------------------------------
   localparam logic [8:0] CH_STRIDE = 9'h020;
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_REQ = 5'h04;
   localparam logic [4:0] OFF_STA = 5'h08;
   localparam logic [4:0] OFF_STB = 5'h0c;
   localparam logic [4:0] OFF_PAD = 5'h10;
   localparam logic [4:0] OFF_CNT = 5'h14;
   localparam logic [8:0] ADDR_IRQ_STAT = 9'h100;
   localparam logic [8:0] ADDR_IRQ_MASK = 9'h104;
   localparam logic [8:0] ADDR_CH_STAT = 9'h108;

   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int CTL_EN = 15;
   localparam int CTL_SIZE = 14;
   localparam int CTL_DIR = 13;
   localparam int CTL_HALF = 12;
   localparam int CTL_AMODE = 4;
   localparam int CTL_MODE = 0;
   localparam int REQ_FORCE = 15;
   localparam logic [15:0] RST_REG = 16'h0000;

   // ---------------------------------------------------------------
   // mode encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] MODE_CONT = 2'h0;
   localparam logic [1:0] MODE_ONESHOT = 2'h1;
   localparam logic [1:0] MODE_CONT_PP = 2'h2;
   localparam logic [1:0] MODE_ONESHOT_PP = 2'h3;
   localparam logic [1:0] AMODE_INC = 2'h0;
   localparam logic [1:0] AMODE_NOINC = 2'h1;
   localparam logic [1:0] AMODE_PIA = 2'h2;

   // ---------------------------------------------------------------
   // request sources and their peripheral data addresses
   // ---------------------------------------------------------------
   localparam logic [6:0] SRC_EXT_INT_ZERO = 7'h00;
   localparam logic [6:0] SRC_OUTPUT_COMPARE_ONE = 7'h02;
   localparam logic [6:0] SRC_SERIAL_PERIPHERAL_ONE = 7'h0a;
   localparam logic [6:0] SRC_SERIAL_RECEIVER_ONE = 7'h0b;
   localparam logic [6:0] SRC_CONVERTER_ONE = 7'h0d;
   localparam logic [15:0] PA_SERIAL_RECEIVER_ONE = 16'h0226;
   localparam logic [15:0] PA_SERIAL_PERIPHERAL_ONE = 16'h0248;
   localparam logic [15:0] PA_CONVERTER_ONE = 16'h0300;
   localparam logic [15:0] PA_OC_ONE_PRIMARY = 16'h0182;
   localparam logic [15:0] PA_OC_ONE_SECONDARY = 16'h0180;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic       size;
      logic       dir;
      logic       half;
      logic [1:0] amode;
      logic [1:0] mode;
   } mdc_ctl_t;

   typedef struct packed {
      logic        write;
      logic        mem;
      logic        byte_sz;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mdc_xb_cmd_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_READ  = 2'b01,
      ST_WRITE = 2'b10
   } mdc_st_t;

endpackage

// ===== src/mdc_top.sv
// Purpose: eight-channel dma controller between peripherals and dual_port_memory
// Assumes: peripheral requests and offsets come from logic on hclk
// Notes:   registers over ahb-lite; data moves over a private transaction bus
//
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps

module mdc_top
(
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic [31:0]               hrdata,
   output logic                      hresp,
   input  wire logic [127:0]         periph_req,
   input  wire logic [15:0]          pia_offset,
   output logic                      xb_valid,
   output mdc_pkg::mdc_xb_cmd_t      xb_cmd,
   input  wire logic                 xb_ready,
   input  wire logic [15:0]          xb_rdata,
   output logic                      irq
);

   localparam int N = mdc_pkg::NCH;

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   mdc_pkg::mdc_ctl_t ctl [N];
   logic [6:0]        src [N];
   logic [15:0]       sta [N];
   logic [15:0]       stb [N];
   logic [15:0]       pad [N];
   logic [9:0]        cnt [N];
   logic [15:0]       ptr [N];
   logic [9:0]        idx [N];
   logic [N-1:0]      en;
   logic [N-1:0]      force_req;
   logic [N-1:0]      ping;
   logic [N-1:0]      pend;
   logic [N-1:0]      irq_stat;
   logic [N-1:0]      irq_mask;
   logic              dp_wr;
   logic              dp_rd;
   logic              rd_done;
   logic [8:0]        dp_addr;
   logic              accept;
   logic              wr_go;
   logic [2:0]        wr_ch;
   logic [4:0]        wr_off;
   logic              wr_glob;
   mdc_pkg::mdc_st_t  st;
   logic [2:0]        cur;
   logic [15:0]       maddr;
   logic [15:0]       data;
   logic              gnt_any;
   logic [2:0]        gnt;
   logic              done;
   logic [N-1:0]      ev;
   logic [31:0]       next_rdata;

   // ---------------------------------------------------------------
   // ahb-lite slave: writes zero wait, reads one wait state
   // ---------------------------------------------------------------
   assign accept = hsel & htrans[1] & hready;
   assign hreadyout = !(dp_rd & !rd_done);
   assign hresp = 1'b0;
   assign wr_go = dp_wr;
   assign wr_ch = dp_addr[7:5];
   assign wr_off = dp_addr[4:0];
   assign wr_glob = dp_addr[8];

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_wr <= 1'b0;
         dp_rd <= 1'b0;
         dp_addr <= 9'h000;
      end
      else if (hready)
      begin
         dp_wr <= accept & hwrite;
         dp_rd <= accept & !hwrite;
         dp_addr <= haddr[8:0];
      end
   end

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (wr_glob)
      begin
         case (dp_addr)
            mdc_pkg::ADDR_IRQ_STAT: next_rdata = {24'h00_0000, irq_stat};
            mdc_pkg::ADDR_IRQ_MASK: next_rdata = {24'h00_0000, irq_mask};
            mdc_pkg::ADDR_CH_STAT:
               next_rdata = {12'h000, st != mdc_pkg::ST_IDLE, cur, ping, en};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
      else
      begin
         case (wr_off)
            mdc_pkg::OFF_CTRL:
               next_rdata = {16'h0000, en[wr_ch], ctl[wr_ch].size, ctl[wr_ch].dir,
                             ctl[wr_ch].half, 6'h00, ctl[wr_ch].amode, 2'h0,
                             ctl[wr_ch].mode};
            mdc_pkg::OFF_REQ:
               next_rdata = {16'h0000, force_req[wr_ch], 8'h00, src[wr_ch]};
            // start address reads return the live buffer pointer
            mdc_pkg::OFF_STA: next_rdata = {16'h0000, ptr[wr_ch]};
            mdc_pkg::OFF_STB: next_rdata = {16'h0000, ptr[wr_ch]};
            mdc_pkg::OFF_PAD: next_rdata = {16'h0000, pad[wr_ch]};
            mdc_pkg::OFF_CNT: next_rdata = {22'h00_0000, cnt[wr_ch]};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hrdata <= 32'h0000_0000;
         rd_done <= 1'b0;
      end
      else if (dp_rd & !rd_done)
      begin
         hrdata <= next_rdata;
         rd_done <= 1'b1;
      end
      else
      begin
         rd_done <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // per-channel configuration registers
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < N; i++)
         begin
            ctl[i] <= '0;
            src[i] <= 7'h00;
            sta[i] <= mdc_pkg::RST_REG;
            stb[i] <= mdc_pkg::RST_REG;
            pad[i] <= mdc_pkg::RST_REG;
            cnt[i] <= 10'h000;
         end
      end
      else if (wr_go & !wr_glob)
      begin
         case (wr_off)
            mdc_pkg::OFF_CTRL:
            begin
               ctl[wr_ch].size <= hwdata[mdc_pkg::CTL_SIZE];
               ctl[wr_ch].dir <= hwdata[mdc_pkg::CTL_DIR];
               ctl[wr_ch].half <= hwdata[mdc_pkg::CTL_HALF];
               ctl[wr_ch].amode <= hwdata[mdc_pkg::CTL_AMODE +: 2];
               ctl[wr_ch].mode <= hwdata[mdc_pkg::CTL_MODE +: 2];
            end
            mdc_pkg::OFF_REQ:
            begin
               src[wr_ch] <= hwdata[6:0];
               // known sources other than external interrupt zero preload their peripheral data address
               case (hwdata[6:0])
                  mdc_pkg::SRC_SERIAL_RECEIVER_ONE:
                     pad[wr_ch] <= mdc_pkg::PA_SERIAL_RECEIVER_ONE;
                  mdc_pkg::SRC_SERIAL_PERIPHERAL_ONE:
                     pad[wr_ch] <= mdc_pkg::PA_SERIAL_PERIPHERAL_ONE;
                  mdc_pkg::SRC_CONVERTER_ONE:
                     pad[wr_ch] <= mdc_pkg::PA_CONVERTER_ONE;
                  mdc_pkg::SRC_OUTPUT_COMPARE_ONE:
                     pad[wr_ch] <= mdc_pkg::PA_OC_ONE_PRIMARY;
                  // external interrupt zero has no data address: keep it
                  default: pad[wr_ch] <= pad[wr_ch];
               endcase
            end
            mdc_pkg::OFF_STA: sta[wr_ch] <= hwdata[15:0];
            mdc_pkg::OFF_STB: stb[wr_ch] <= hwdata[15:0];
            // secondary compare at PA_OC_ONE_SECONDARY is reached by writing here
            mdc_pkg::OFF_PAD: pad[wr_ch] <= hwdata[15:0];
            mdc_pkg::OFF_CNT: cnt[wr_ch] <= hwdata[9:0];
            default: ctl[wr_ch] <= ctl[wr_ch];
         endcase
      end
   end

   // ---------------------------------------------------------------
   // request capture and fixed priority arbitration
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pend <= '0;
      else
      begin
         for (int i = 0; i < N; i++)
         begin
            // a new request in the grant cycle survives the clear
            if (en[i] & periph_req[src[i]])
               pend[i] <= 1'b1;
            else if (st == mdc_pkg::ST_IDLE && gnt_any && gnt == 3'(i))
               pend[i] <= 1'b0;
         end
      end
   end

   always_comb
   begin
      gnt_any = 1'b0;
      gnt = 3'h0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (en[i] & (pend[i] | force_req[i]))
         begin
            gnt_any = 1'b1;
            gnt = 3'(i);
         end
      end
   end

   // ---------------------------------------------------------------
   // transfer engine on the private transaction bus
   // ---------------------------------------------------------------
   assign done = (st == mdc_pkg::ST_WRITE) & xb_ready;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st <= mdc_pkg::ST_IDLE;
         cur <= 3'h0;
         maddr <= 16'h0000;
         data <= 16'h0000;
         xb_valid <= 1'b0;
         xb_cmd <= '0;
      end
      else
      begin
         case (st)
            mdc_pkg::ST_IDLE:
            begin
               if (gnt_any)
               begin
                  cur <= gnt;
                  xb_valid <= 1'b1;
                  xb_cmd.write <= 1'b0;
                  xb_cmd.byte_sz <= ctl[gnt].size;
                  xb_cmd.wdata <= 16'h0000;
                  // peripheral indirect adds the peripheral's offset
                  if (ctl[gnt].amode[1])
                     maddr <= (ping[gnt] ? stb[gnt] : sta[gnt]) + pia_offset;
                  else
                     maddr <= ptr[gnt];
                  if (ctl[gnt].dir)
                  begin
                     xb_cmd.mem <= 1'b1;
                     xb_cmd.addr <= ctl[gnt].amode[1] ?
                        (ping[gnt] ? stb[gnt] : sta[gnt]) + pia_offset : ptr[gnt];
                  end
                  else
                  begin
                     xb_cmd.mem <= 1'b0;
                     xb_cmd.addr <= pad[gnt];
                  end
                  st <= mdc_pkg::ST_READ;
               end
            end
            mdc_pkg::ST_READ:
            begin
               if (xb_ready)
               begin
                  data <= xb_rdata;
                  xb_cmd.write <= 1'b1;
                  xb_cmd.mem <= !ctl[cur].dir;
                  xb_cmd.addr <= ctl[cur].dir ? pad[cur] : maddr;
                  xb_cmd.wdata <= ctl[cur].size ? {8'h00, xb_rdata[7:0]} : xb_rdata;
                  st <= mdc_pkg::ST_WRITE;
               end
            end
            mdc_pkg::ST_WRITE:
            begin
               if (xb_ready)
               begin
                  xb_valid <= 1'b0;
                  xb_cmd <= '0;
                  st <= mdc_pkg::ST_IDLE;
               end
            end
            default: st <= mdc_pkg::ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // channel progress: enable, force, pointer, count, ping-pong
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         en <= '0;
         force_req <= '0;
         ping <= '0;
         for (int i = 0; i < N; i++)
         begin
            ptr[i] <= mdc_pkg::RST_REG;
            idx[i] <= 10'h000;
         end
      end
      else
      begin
         if (done)
         begin
            force_req[cur] <= 1'b0;
            if (idx[cur] == cnt[cur])
            begin
               idx[cur] <= 10'h000;
               case (ctl[cur].mode)
                  mdc_pkg::MODE_CONT: ptr[cur] <= sta[cur];
                  mdc_pkg::MODE_ONESHOT:
                  begin
                     en[cur] <= 1'b0;
                     ptr[cur] <= sta[cur];
                  end
                  mdc_pkg::MODE_CONT_PP:
                  begin
                     ping[cur] <= !ping[cur];
                     ptr[cur] <= ping[cur] ? sta[cur] : stb[cur];
                  end
                  default:
                  begin
                     // one block from each buffer, then stop
                     ping[cur] <= !ping[cur];
                     ptr[cur] <= ping[cur] ? sta[cur] : stb[cur];
                     if (ping[cur])
                        en[cur] <= 1'b0;
                  end
               endcase
            end
            else
            begin
               idx[cur] <= idx[cur] + 10'h001;
               if (ctl[cur].amode == mdc_pkg::AMODE_INC)
                  ptr[cur] <= ptr[cur] + (ctl[cur].size ? 16'h0001 : 16'h0002);
            end
         end
         if (wr_go & !wr_glob)
         begin
            if (wr_off == mdc_pkg::OFF_CTRL)
            begin
               en[wr_ch] <= hwdata[mdc_pkg::CTL_EN];
               if (hwdata[mdc_pkg::CTL_EN] & !en[wr_ch])
               begin
                  ptr[wr_ch] <= sta[wr_ch];
                  idx[wr_ch] <= 10'h000;
                  ping[wr_ch] <= 1'b0;
               end
            end
            // software may set force but never clear it
            if (wr_off == mdc_pkg::OFF_REQ && hwdata[mdc_pkg::REQ_FORCE])
               force_req[wr_ch] <= 1'b1;
            if (wr_off == mdc_pkg::OFF_STA && !en[wr_ch])
               ptr[wr_ch] <= hwdata[15:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // interrupt status, write one to clear, set wins
   // ---------------------------------------------------------------
   always_comb
   begin
      ev = '0;
      if (done)
      begin
         if (ctl[cur].half)
            ev[cur] = idx[cur] == (cnt[cur] >> 1);
         else
            ev[cur] = idx[cur] == cnt[cur];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_stat <= '0;
         irq_mask <= '0;
         irq <= 1'b0;
      end
      else
      begin
         if (wr_go && dp_addr == mdc_pkg::ADDR_IRQ_STAT)
            irq_stat <= (irq_stat & ~hwdata[N-1:0]) | ev;
         else
            irq_stat <= irq_stat | ev;
         if (wr_go && dp_addr == mdc_pkg::ADDR_IRQ_MASK)
            irq_mask <= hwdata[N-1:0];
         irq <= |(irq_stat & irq_mask);
      end
   end

endmodule

// ===== testbench/mdc_top_props.sv
// Purpose: port-level checks of the dma controller
// Assumes: single hclk domain, hresetn async active low
// Notes:   bound to mdc_top from the tb file
`timescale 1ns/1ps
module mdc_top_props
(
   input wire logic                 hclk,
   input wire logic                 hresetn,
   input wire logic                 hsel,
   input wire logic [31:0]          haddr,
   input wire logic [1:0]           htrans,
   input wire logic                 hwrite,
   input wire logic [2:0]           hsize,
   input wire logic [31:0]          hwdata,
   input wire logic                 hready,
   input wire logic                 hreadyout,
   input wire logic [31:0]          hrdata,
   input wire logic                 hresp,
   input wire logic [127:0]         periph_req,
   input wire logic [15:0]          pia_offset,
   input wire logic                 xb_valid,
   input wire mdc_pkg::mdc_xb_cmd_t xb_cmd,
   input wire logic                 xb_ready,
   input wire logic [15:0]          xb_rdata,
   input wire logic                 irq
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   hresp_okay_a: assert property (hresp == 1'b0) else $error("hresp not okay");
   read_wait_a: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   write_nowait_a: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
      else $error("write stalled");
   cmd_hold_a: assert property (xb_valid && !xb_ready |=> xb_valid && $stable(xb_cmd))
      else $error("xb command moved before ready");
   read_first_a: assert property ($rose(xb_valid) |-> !xb_cmd.write) else $error("transfer not opened by read");
   dir_swap_a: assert property (xb_valid && xb_ready && !xb_cmd.write |=>
      xb_valid && xb_cmd.write && xb_cmd.mem != $past(xb_cmd.mem)) else $error("write side wrong");
   write_end_a: assert property (xb_valid && xb_ready && xb_cmd.write |=> !xb_valid)
      else $error("valid held after write");
   byte_high_a: assert property (xb_valid && xb_cmd.write && xb_cmd.byte_sz |-> xb_cmd.wdata[15:8] == 8'h00)
      else $error("byte write high byte set");
endmodule

// ===== testbench/mdc_periph_model.sv
// Purpose: far side of the transaction bus, memory and peripherals
// Assumes: delay sets wait cycles before ready
// Notes:   read data is address xor 5a5a; idle data toggles
`timescale 1ns/1ps
module mdc_periph_model
(
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 xb_valid,
   input  wire mdc_pkg::mdc_xb_cmd_t xb_cmd,
   input  wire logic [3:0]           delay,
   output logic                      xb_ready,
   output logic [15:0]               xb_rdata
);
   logic [3:0] cnt;
   // one access at a time, ready held one cycle only
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt      <= 4'h0;
         xb_ready <= 1'b0;
         xb_rdata <= 16'h0000;
      end
      else if (xb_valid && !xb_ready && cnt >= delay)
      begin
         cnt      <= 4'h0;
         xb_ready <= 1'b1;
         xb_rdata <= xb_cmd.addr ^ 16'h5a5a;
      end
      else
      begin
         cnt      <= xb_valid ? cnt + 4'h1 : 4'h0;
         xb_ready <= 1'b0;
         xb_rdata <= ~xb_rdata;
      end
   end
endmodule

// ===== testbench/tb.sv
// Purpose: self-checking bench of the dma controller
// Assumes: ahb-lite master tasks, far side model
// Notes:   scenarios cover decode, forced and requested transfers
`timescale 1ns/1ps
module tb;
   logic                 hclk = 1'b0;
   logic                 hresetn = 1'b0;
   logic [31:0]          haddr = 32'h0;
   logic [1:0]           htrans = 2'h0;
   logic                 hwrite = 1'b0;
   logic [31:0]          hwdata = 32'h0;
   logic [127:0]         periph_req = '0;
   logic [3:0]           delay = 4'h0;
   logic [15:0]          pia_offset = 16'h0000;
   logic                 hreadyout, hresp, xb_valid, xb_ready, irq;
   logic [31:0]          hrdata;
   logic [15:0]          xb_rdata;
   mdc_pkg::mdc_xb_cmd_t xb_cmd, r, w;
   int                   num_errors = 0;
   int                   tests_run = 0;
   int                   cycles = 0;
   logic [31:0]          q;
   always #2.5 hclk = ~hclk;
   mdc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .periph_req(periph_req), .pia_offset(pia_offset),
      .xb_valid(xb_valid), .xb_cmd(xb_cmd), .xb_ready(xb_ready), .xb_rdata(xb_rdata), .irq(irq));
   mdc_periph_model i_model (.hclk(hclk), .hresetn(hresetn), .xb_valid(xb_valid), .xb_cmd(xb_cmd),
      .delay(delay), .xb_ready(xb_ready), .xb_rdata(xb_rdata));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task finish_test;
      $display("errors %0d of %0d checks", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge hclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         finish_test;
      end
   end
   task check(input string name, input logic [39:0] exp, input logic [39:0] got);
      tests_run++;
      if (exp !== got)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task bus(input logic wr, input logic [8:0] a, input logic [15:0] d);
      logic ok;
      @(posedge hclk);
      haddr  <= {23'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do begin @(negedge hclk); ok = hreadyout; @(posedge hclk); end while (!ok);
      htrans <= 2'h0;
      hwdata <= {16'h0, d};
      do begin @(negedge hclk); ok = hreadyout; q = hrdata; @(posedge hclk); end while (!ok);
   endtask
   task xfer(output mdc_pkg::mdc_xb_cmd_t c);
      int n;
      n = 0;
      do begin @(negedge hclk); c = xb_cmd; n++; end while (!(xb_valid && xb_ready) && n < 60);
      check("xfer handshake", 40'h1, {39'h0, xb_valid & xb_ready});
      @(posedge hclk);
   endtask
   task pulse(input int s);
      @(posedge hclk);
      periph_req[s] <= 1'b1;
      @(posedge hclk);
      periph_req[s] <= 1'b0;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task test_decode;
      static logic [6:0]  code [4] = '{7'h0b, 7'h0a, 7'h0d, 7'h02};
      static logic [15:0] pad [4] = '{16'h0226, 16'h0248, 16'h0300, 16'h0182};
      bus(0, 9'h000, 16'h0);
      check("ctrl reset", 40'h0, {8'h0, q});
      for (int i = 0; i < 4; i++)
      begin
         bus(1, 9'h0e4, {9'h0, code[i]});
         bus(0, 9'h0f0, 16'h0);
         check("source pad", {24'h0, pad[i]}, {8'h0, q});
      end
      bus(1, 9'h0e4, 16'h0000);
      bus(0, 9'h0f0, 16'h0);
      check("ext int pad kept", 40'h0182, {8'h0, q});
      bus(1, 9'h0f0, 16'h0180);
      bus(0, 9'h0f0, 16'h0);
      check("secondary pad", 40'h0180, {8'h0, q});
      bus(0, 9'h1fc, 16'h0);
      check("unmapped", 40'h0, {8'h0, q});
      $display("test decode done");
   endtask
   task test_forced;
      bus(1, 9'h014, 16'h0001);
      bus(1, 9'h008, 16'h0800);
      bus(1, 9'h004, 16'h000b);
      bus(1, 9'h104, 16'h0001);
      bus(1, 9'h000, 16'h8001);
      bus(1, 9'h004, 16'h800b);
      xfer(r);
      xfer(w);
      check("rd 0", {22'h0, 2'b00, 16'h0226}, {22'h0, r.write, r.mem, r.addr});
      check("wr 0", {5'h0, 3'b110, 16'h0800, 16'h587c}, {5'h0, w});
      bus(0, 9'h100, 16'h0);
      check("no early event", 40'h0, {8'h0, q});
      bus(1, 9'h004, 16'h800b);
      xfer(r);
      xfer(w);
      check("wr 1 addr", 40'h0802, {24'h0, w.addr});
      repeat (3) @(posedge hclk);
      check("irq up", 40'h1, {39'h0, irq});
      bus(0, 9'h000, 16'h0);
      check("one-shot off", 40'h0001, {8'h0, q});
      bus(1, 9'h100, 16'h0001);
      bus(0, 9'h100, 16'h0);
      check("stat cleared", 40'h0, {8'h0, q});
      repeat (2) @(posedge hclk);
      check("irq down", 40'h0, {39'h0, irq});
      $display("test forced done");
   endtask
   task test_request;
      delay <= 4'h3;
      bus(1, 9'h054, 16'h0001);
      bus(1, 9'h048, 16'h0900);
      bus(1, 9'h04c, 16'h0a00);
      bus(1, 9'h044, 16'h000d);
      bus(1, 9'h040, 16'hd012);
      bus(1, 9'h0b4, 16'h0000);
      bus(1, 9'h0a8, 16'h0b00);
      bus(1, 9'h0a4, 16'h000d);
      bus(1, 9'h0a0, 16'ha001);
      pulse(13);
      xfer(r);
      xfer(w);
      check("ch2 rd", {22'h0, 2'b00, 16'h0300}, {22'h0, r.write, r.mem, r.addr});
      check("ch2 wr", {5'h0, 3'b111, 16'h0900, 16'h005a}, {5'h0, w});
      xfer(r);
      xfer(w);
      check("ch5 rd", {22'h0, 2'b01, 16'h0b00}, {22'h0, r.write, r.mem, r.addr});
      check("ch5 wr", {5'h0, 3'b100, 16'h0300, 16'h515a}, {5'h0, w});
      repeat (3) @(posedge hclk);
      bus(0, 9'h100, 16'h0);
      check("half events", 40'h24, {8'h0, q});
      check("masked irq", 40'h0, {39'h0, irq});
      pulse(13);
      xfer(r);
      xfer(w);
      check("no inc", 40'h0900, {24'h0, w.addr});
      pulse(13);
      xfer(r);
      xfer(w);
      check("ping-pong", 40'h0a00, {24'h0, w.addr});
      $display("test request done");
   endtask
   task test_pia;
      pia_offset <= 16'h0010;
      bus(1, 9'h028, 16'h0c00);
      bus(1, 9'h02c, 16'h0d00);
      bus(1, 9'h024, 16'h000a);
      bus(1, 9'h020, 16'ha023);
      pulse(10);
      xfer(r);
      xfer(w);
      check("pia rd", {22'h0, 2'b01, 16'h0c10}, {22'h0, r.write, r.mem, r.addr});
      check("pia wr", {5'h0, 3'b100, 16'h0248, 16'h564a}, {5'h0, w});
      pulse(10);
      xfer(r);
      xfer(w);
      check("pp b rd", 40'h0d10, {24'h0, r.addr});
      repeat (2) @(posedge hclk);
      bus(0, 9'h020, 16'h0);
      check("pp one-shot off", 40'h2023, {8'h0, q});
      bus(0, 9'h108, 16'h0);
      check("channel status", 40'h1_0404, {8'h0, q});
      $display("test pia done");
   endtask
   initial
   begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      test_decode;
      test_forced;
      test_request;
      test_pia;
      finish_test;
   end
endmodule
bind mdc_top mdc_top_props i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .periph_req(periph_req),
   .pia_offset(pia_offset), .xb_valid(xb_valid), .xb_cmd(xb_cmd), .xb_ready(xb_ready),
   .xb_rdata(xb_rdata), .irq(irq));
